// file: rtl/atc_pkg.sv
// Constants and types shared by the acquisition trigger controller.
// Notes on behaviour
// - Trigger function resets off; off means no evaluation.
// - No sources enabled: start records at once.
// - After start, capture begins on start trigger.
// - Single mode: one trigger, one record, halt.
// - Repeat mode: rearm after each record until stop.
// - Count mode: 2 to 10000 triggers, then halt.
// - Repeat: triggers ignored during post-record processing.
// - First stop finishes record; second stops immediately.
// - Timing selects start, stop or start/stop use.
// - Forced and interval triggers only start measurement.
// - No stop trigger: end at recording length.
// - Stop timing: single ends, repeat restarts.
// - Start/stop timing: wait start, record until stop.
// - OR fires only on unsatisfied-to-satisfied change; here any enabled channel rising fires it, even while another holds.
// - AND fires while all enabled conditions hold.
// - Only channels with triggers configured take part.
// - Triggers ignored while pre-trigger portion records.
// - Every applied trigger pulses the trigger output.
package atc_pkg;

  // ***********************************************************
  // Register map (byte addresses)
  // ***********************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_START_MASK = 8'h04;
  localparam logic [7:0] OFF_STOP_MASK = 8'h08;
  localparam logic [7:0] OFF_REC_LEN = 8'h0C;
  localparam logic [7:0] OFF_PRE_LEN = 8'h10;
  localparam logic [7:0] OFF_CNT_SET = 8'h14;
  localparam logic [7:0] OFF_CMD = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_CNT_DONE = 8'h20;
  localparam logic [7:0] OFF_SMP_CNT = 8'h24;

  // ***********************************************************
  // Field positions
  // ***********************************************************
  localparam int CTRL_EN = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_TIM = 3;
  localparam int CTRL_START_AND = 5;
  localparam int CTRL_STOP_AND = 6;
  localparam int CTRL_IVAL_EN = 7;
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_FORCE = 2;
  localparam int STAT_STOP_PEND = 3;
  localparam int STAT_MEAS = 4;

  // ***********************************************************
  // Modes, timing and reset values
  // ***********************************************************
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_REPEAT = 2'h1;
  localparam logic [1:0] MODE_COUNT = 2'h2;
  localparam logic [1:0] TIM_START = 2'h0;
  localparam logic [1:0] TIM_STOP = 2'h1;
  localparam logic [1:0] TIM_BOTH = 2'h2;
  localparam logic [31:0] REC_LEN_RST = 32'h0000_03E8;
  localparam logic [13:0] CNT_MIN = 14'h0002;
  localparam logic [13:0] CNT_MAX = 14'h2710;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PRE = 3'b001,
    ST_TWAIT = 3'b010,
    ST_REC = 3'b011,
    ST_PROC = 3'b100
  } atc_state_e;

endpackage

// file: rtl/atc_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module atc_sync import atc_pkg::*; #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous inputs and filtered levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] f1;
    logic [WIDTH-1:0] f2;
    logic [WIDTH-1:0] f3;
    logic [WIDTH-1:0] q;
  } atc_sync_s;

  atc_sync_s s_r;
  atc_sync_s s_nxt;
  logic [WIDTH-1:0] agree;

  // A bit only moves once the second and third stages agree.
  always_comb begin
    s_nxt = s_r;
    agree = ~(s_r.f2 ^ s_r.f3);
    s_nxt.f1 = d;
    s_nxt.f2 = s_r.f1;
    s_nxt.f3 = s_r.f2;
    s_nxt.q = (s_r.q & ~agree) | (s_r.f3 & agree);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q;

endmodule

// file: rtl/atc_comb.sv
// AND/OR combiner of per-channel trigger conditions.
`timescale 1ns/1ps
module atc_comb import atc_pkg::*; #(
  parameter int NCH = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Conditions and selection
  input wire logic [NCH-1:0] cond,
  input wire logic [NCH-1:0] mask,
  input wire logic and_sel,
  // Combined trigger
  output logic hit
);

  typedef struct packed {
    logic [NCH-1:0] prev;
  } atc_comb_s;

  atc_comb_s s_r;
  atc_comb_s s_nxt;
  logic [NCH-1:0] cur;

  always_comb begin
    s_nxt = s_r;
    cur = cond & mask;
    s_nxt.prev = cur;
    if (and_sel) begin
      hit = (mask != '0) && ((cond | ~mask) == '1);
    end else begin
      hit = |(cur & ~s_r.prev);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  or_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    !and_sel |-> (hit == ((cond & mask & ~$past(cond & mask)) != '0)))
    else $error("OR trigger does not follow a rising condition");

endmodule

// file: rtl/atc_top.sv
// Acquisition trigger controller with its APB register file.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
module atc_top import atc_pkg::*; #(
  parameter int NCH = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger detectors and panel controls
  input wire logic [NCH-1:0] cond_in,
  input wire logic start_key,
  input wire logic stop_key,
  input wire logic force_key,
  input wire logic ival_tick,
  // Post-recording processing handshake
  input wire logic proc_done,
  // Status to the acquisition engine
  output logic trig_out,
  output logic measuring,
  output logic recording,
  output logic trig_wait
);

  // ***********************************************************
  // State
  // ***********************************************************
  typedef struct packed {
    atc_state_e st;
    logic trig_en;
    logic [1:0] mode;
    logic [1:0] timing;
    logic start_and;
    logic stop_and;
    logic ival_en;
    logic [NCH-1:0] start_mask;
    logic [NCH-1:0] stop_mask;
    logic [31:0] rec_len;
    logic [31:0] pre_len;
    logic [31:0] smp_cnt;
    logic [13:0] cnt_set;
    logic [13:0] cnt_done;
    logic stop_pend;
    logic trig_out;
    logic measuring;
    logic recording;
    logic trig_wait;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] key_d;
  } atc_top_s;

  atc_top_s s_r;
  atc_top_s s_nxt;

  logic [NCH+3:0] sync_q;
  logic [NCH-1:0] cond_s;
  logic [3:0] key_s;
  logic [3:0] key_edge;
  logic cs_hit;
  logic ss_hit;
  logic setup;
  logic wr_acc;
  logic cmd_wr;
  logic start_cmd;
  logic stop_cmd;
  logic force_w;
  logic free_w;
  logic start_hit;
  logic stop_hit;
  logic rec_full;
  logic pre_full;
  logic rec_end;

  // ***********************************************************
  // Helper functions
  // ***********************************************************
  // True on the last sample of a span of len samples.
  function automatic logic reached(input logic [31:0] cnt, input logic [31:0] len);
    reached = ({1'b0, cnt} + 33'h0_0000_0001) >= {1'b0, len};
  endfunction

  // Programmed counts outside the legal range are pulled to the nearest limit.
  function automatic logic [13:0] clamp_cnt(input logic [31:0] v);
    if (v < 32'(CNT_MIN)) begin
      clamp_cnt = CNT_MIN;
    end else if (v > 32'(CNT_MAX)) begin
      clamp_cnt = CNT_MAX;
    end else begin
      clamp_cnt = v[13:0];
    end
  endfunction

  // First state after a start or a rearm.
  function automatic atc_state_e first_state(input logic free, input atc_top_s s);
    if (free || s.timing == TIM_STOP) begin
      first_state = ST_REC;
    end else if (s.pre_len != 32'h0000_0000) begin
      first_state = ST_PRE;
    end else begin
      first_state = ST_TWAIT;
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFF_CTRL) || (a == OFF_START_MASK) || (a == OFF_STOP_MASK) ||
             (a == OFF_REC_LEN) || (a == OFF_PRE_LEN) || (a == OFF_CNT_SET) ||
             (a == OFF_CMD) || (a == OFF_STATUS) || (a == OFF_CNT_DONE) ||
             (a == OFF_SMP_CNT);
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] a, input atc_top_s s);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      OFF_CTRL: begin
        v[CTRL_EN] = s.trig_en;
        v[CTRL_MODE +: 2] = s.mode;
        v[CTRL_TIM +: 2] = s.timing;
        v[CTRL_START_AND] = s.start_and;
        v[CTRL_STOP_AND] = s.stop_and;
        v[CTRL_IVAL_EN] = s.ival_en;
      end
      OFF_START_MASK: v = 32'(s.start_mask);
      OFF_STOP_MASK: v = 32'(s.stop_mask);
      OFF_REC_LEN: v = s.rec_len;
      OFF_PRE_LEN: v = s.pre_len;
      OFF_CNT_SET: v = 32'(s.cnt_set);
      OFF_STATUS: begin
        v[2:0] = s.st;
        v[STAT_STOP_PEND] = s.stop_pend;
        v[STAT_MEAS] = s.measuring;
      end
      OFF_CNT_DONE: v = 32'(s.cnt_done);
      OFF_SMP_CNT: v = s.smp_cnt;
      default: v = 32'h0000_0000;
    endcase
    rd_word = v;
  endfunction

  // ***********************************************************
  // Input conditioning and combining
  // ***********************************************************
  // Detector flags and panel keys arrive from outside this clock domain.
  atc_sync #(
    .WIDTH(NCH + 4)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({ival_tick, force_key, stop_key, start_key, cond_in}),
    .q(sync_q)
  );

  assign cond_s = sync_q[NCH-1:0];
  assign key_s = sync_q[NCH+3:NCH];

  atc_comb #(
    .NCH(NCH)
  ) u_start_comb (
    .pclk(pclk),
    .presetn(presetn),
    .cond(cond_s),
    .mask(s_r.start_mask),
    .and_sel(s_r.start_and),
    .hit(cs_hit)
  );

  atc_comb #(
    .NCH(NCH)
  ) u_stop_comb (
    .pclk(pclk),
    .presetn(presetn),
    .cond(cond_s),
    .mask(s_r.stop_mask),
    .and_sel(s_r.stop_and),
    .hit(ss_hit)
  );

  // ***********************************************************
  // Commands and trigger qualification
  // ***********************************************************
  always_comb begin
    key_edge = key_s & ~s_r.key_d;
    setup = psel && !penable;
    wr_acc = psel && penable && s_r.pready && pwrite && !s_r.pslverr;
    cmd_wr = wr_acc && (paddr == OFF_CMD);
    start_cmd = (cmd_wr && pwdata[CMD_START]) || key_edge[0];
    stop_cmd = (cmd_wr && pwdata[CMD_STOP]) || key_edge[1];
    force_w = (cmd_wr && pwdata[CMD_FORCE]) || key_edge[2];
    free_w = !s_r.trig_en ||
             (s_r.start_mask == '0 && s_r.stop_mask == '0 && !s_r.ival_en);
    start_hit = s_r.trig_en && (cs_hit || force_w || (s_r.ival_en && key_edge[3]));
    stop_hit = s_r.trig_en && (s_r.timing != TIM_START) && ss_hit;
    rec_full = reached(s_r.smp_cnt, s_r.rec_len);
    pre_full = reached(s_r.smp_cnt, s_r.pre_len);
    rec_end = (s_r.st == ST_REC) && (rec_full || stop_hit);
  end

  // ***********************************************************
  // Next state
  // ***********************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.key_d = key_s;
    s_nxt.trig_out = 1'b0;
    s_nxt.smp_cnt = s_r.smp_cnt + 32'h0000_0001;

    // Register writes take effect at the access edge only.
    if (wr_acc) begin
      unique case (paddr)
        OFF_CTRL: begin
          s_nxt.trig_en = pwdata[CTRL_EN];
          s_nxt.mode = pwdata[CTRL_MODE +: 2];
          s_nxt.timing = pwdata[CTRL_TIM +: 2];
          s_nxt.start_and = pwdata[CTRL_START_AND];
          s_nxt.stop_and = pwdata[CTRL_STOP_AND];
          s_nxt.ival_en = pwdata[CTRL_IVAL_EN];
        end
        OFF_START_MASK: s_nxt.start_mask = pwdata[NCH-1:0];
        OFF_STOP_MASK: s_nxt.stop_mask = pwdata[NCH-1:0];
        OFF_REC_LEN: s_nxt.rec_len = pwdata;
        OFF_PRE_LEN: s_nxt.pre_len = pwdata;
        OFF_CNT_SET: s_nxt.cnt_set = clamp_cnt(pwdata);
        default: begin
        end
      endcase
    end

    unique case (s_r.st)
      ST_IDLE: begin
        s_nxt.smp_cnt = 32'h0000_0000;
        s_nxt.stop_pend = 1'b0;
        if (start_cmd) begin
          s_nxt.cnt_done = 14'h0000;
          s_nxt.st = first_state(free_w, s_r);
        end
      end
      ST_PRE: begin
        if (stop_cmd) begin
          s_nxt.st = ST_IDLE;
        end else if (free_w) begin
          s_nxt.st = ST_REC;
          s_nxt.smp_cnt = 32'h0000_0000;
        end else if (pre_full) begin
          s_nxt.st = ST_TWAIT;
        end
      end
      ST_TWAIT: begin
        if (stop_cmd) begin
          s_nxt.st = ST_IDLE;
        end else if (free_w) begin
          s_nxt.st = ST_REC;
          s_nxt.smp_cnt = 32'h0000_0000;
        end else if (start_hit) begin
          s_nxt.trig_out = 1'b1;
          s_nxt.st = ST_REC;
          s_nxt.smp_cnt = 32'h0000_0000;
        end
      end
      ST_REC: begin
        if (stop_cmd && s_r.stop_pend) begin
          s_nxt.st = ST_IDLE;
        end else if (rec_end) begin
          s_nxt.trig_out = stop_hit;
          s_nxt.cnt_done = s_r.cnt_done + 14'h0001;
          s_nxt.smp_cnt = 32'h0000_0000;
          if (s_r.stop_pend || stop_cmd || s_r.mode == MODE_SINGLE) begin
            s_nxt.st = ST_IDLE;
          end else if (s_r.mode == MODE_COUNT &&
                       s_r.cnt_done + 14'h0001 >= s_r.cnt_set) begin
            s_nxt.st = ST_IDLE;
          end else begin
            s_nxt.st = ST_PROC;
          end
        end else if (stop_cmd) begin
          s_nxt.stop_pend = 1'b1;
        end
      end
      ST_PROC: begin
        s_nxt.smp_cnt = 32'h0000_0000;
        if (stop_cmd) begin
          s_nxt.st = ST_IDLE;
        end else if (proc_done) begin
          s_nxt.st = first_state(free_w, s_r);
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    // Outputs are registered copies of the coming state.
    s_nxt.measuring = (s_nxt.st != ST_IDLE);
    s_nxt.recording = (s_nxt.st == ST_PRE) || (s_nxt.st == ST_REC);
    s_nxt.trig_wait = (s_nxt.st == ST_TWAIT);

    // APB answers one cycle after setup, so every access has no wait state.
    s_nxt.pready = setup;
    s_nxt.pslverr = setup && !mapped(paddr);
    if (setup && !pwrite) begin
      s_nxt.prdata = rd_word(paddr, s_r);
    end
  end

  // ***********************************************************
  // Registers
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.trig_en <= 1'b0;
      s_r.mode <= MODE_REPEAT;
      s_r.timing <= TIM_START;
      s_r.rec_len <= REC_LEN_RST;
      s_r.cnt_set <= CNT_MIN;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign trig_out = s_r.trig_out;
  assign measuring = s_r.measuring;
  assign recording = s_r.recording;
  assign trig_wait = s_r.trig_wait;

  // ***********************************************************
  // Assertions
  // ***********************************************************
  default clocking atc_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence idle_start_s;
    (s_r.st == ST_IDLE) && start_cmd;
  endsequence

  sequence wait_take_s;
    (s_r.st == ST_TWAIT) && !free_w && !stop_cmd ##1 (s_r.st == ST_REC);
  endsequence

  trig_off_a: assert property (
    (s_r.st == ST_TWAIT && !s_r.trig_en && !stop_cmd) |=> (s_r.st == ST_REC))
    else $error("Disabled trigger function did not run free");
  trig_mute_a: assert property (
    !s_r.trig_en |=> !trig_out)
    else $error("Trigger applied while the function was off");
  free_run_a: assert property (
    (idle_start_s and free_w) |=> (s_r.st == ST_REC) && recording)
    else $error("Free-running start did not record at once");
  start_wait_a: assert property (
    wait_take_s |-> trig_out)
    else $error("Recording began without a start trigger");
  single_halt_a: assert property (
    (rec_end && s_r.mode == MODE_SINGLE) |=> !measuring ##1 (s_r.st == ST_IDLE))
    else $error("Single mode did not halt after one record");
  repeat_proc_a: assert property (
    (rec_end && s_r.mode == MODE_REPEAT && !s_r.stop_pend && !stop_cmd)
      |=> (s_r.st == ST_PROC) && measuring)
    else $error("Repeat mode did not return toward standby");
  count_range_a: assert property (
    (s_r.cnt_set >= CNT_MIN) && (s_r.cnt_set <= CNT_MAX) &&
    (s_r.mode != MODE_COUNT || s_r.st == ST_IDLE || s_r.cnt_done < s_r.cnt_set))
    else $error("Trigger count out of range");
  proc_ignore_a: assert property (
    (s_r.st == ST_PROC) |=> !trig_out)
    else $error("Trigger applied during processing");
  stop_twice_a: assert property (
    (s_r.st == ST_REC && s_r.stop_pend && stop_cmd) |=> (s_r.st == ST_IDLE) && !recording)
    else $error("Second stop did not halt at once");
  pre_ignore_a: assert property (
    (s_r.st == ST_PRE) |=> !trig_out && (s_r.st != ST_REC || free_w || $past(free_w)))
    else $error("Trigger taken during pre-trigger wait");
  trig_pulse_a: assert property (
    (s_r.st == ST_TWAIT && !free_w && !stop_cmd && start_hit) |=>
      trig_out ##1 (!trig_out || $past(stop_hit)))
    else $error("Applied trigger did not pulse the output");

endmodule

// file: sim/atc_partner.sv
// Model of the trigger detectors and the post-record processing engine.
`timescale 1ns/1ps
module atc_partner #(
  parameter int NCH = 8,
  parameter int PD = 40
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Controller status
  input wire logic measuring,
  input wire logic recording,
  input wire logic trig_wait,
  // Requested detector levels
  input wire logic [NCH-1:0] cond_req,
  // Detector levels and processing done
  output logic [NCH-1:0] cond_in,
  output logic proc_done
);
  logic [7:0] cnt_r;

  // Processing takes PD+1 cycles, so a slow engine keeps the controller out of standby.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      cond_in <= '0;
      proc_done <= 1'b0;
    end else begin
      cond_in <= cond_req;
      proc_done <= 1'b0;
      if (measuring && !recording && !trig_wait) begin
        cnt_r <= cnt_r + 8'h01;
        if (cnt_r == PD[7:0]) begin
          proc_done <= 1'b1;
          cnt_r <= 8'h00;
        end
      end else begin
        cnt_r <= 8'h00;
      end
    end
  end
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the acquisition trigger controller.
`timescale 1ns/1ps
module tb_top import atc_pkg::*; ();
  typedef struct packed {
    logic [7:0] a;
    logic wr;
    logic [31:0] d;
    logic [31:0] e;
  } atc_row_s;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] cond_req = 8'h00;
  logic start_key = 1'b0;
  logic stop_key = 1'b0;
  logic force_key = 1'b0;
  logic [7:0] cond_in;
  logic proc_done;
  logic trig_out;
  logic measuring;
  logic recording;
  logic trig_wait;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  atc_row_s rows [9];

  always #4 pclk = ~pclk;

  atc_top #(.NCH(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cond_in(cond_in), .start_key(start_key), .stop_key(stop_key),
    .force_key(force_key), .ival_tick(1'b0), .proc_done(proc_done), .trig_out(trig_out),
    .measuring(measuring), .recording(recording), .trig_wait(trig_wait));

  atc_partner #(.NCH(8), .PD(40)) partner (.pclk(pclk), .presetn(presetn),
    .measuring(measuring), .recording(recording), .trig_wait(trig_wait),
    .cond_req(cond_req), .cond_in(cond_in), .proc_done(proc_done));

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The hang limit is far above the several hundred cycles the tests need.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return recording;
      1: return measuring;
      2: return trig_wait;
      default: return trig_out;
    endcase
  endfunction

  task automatic wt(input int s, input logic v, input int mx, output int n);
    n = 0;
    while (sig(s) !== v && n < mx) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic pulses(input int s, input int len, output int n);
    n = 0;
    repeat (len) begin
      if (sig(s) === 1'b1) n++;
      @(posedge pclk);
    end
  endtask

  initial begin
    logic [31:0] r;
    logic e;
    int n;
    rows[0] = {OFF_CTRL, 1'b0, 32'h0000_0000, 32'h0000_0002};
    rows[1] = {OFF_START_MASK, 1'b0, 32'h0000_0000, 32'h0000_0000};
    rows[2] = {OFF_REC_LEN, 1'b0, 32'h0000_0000, REC_LEN_RST};
    rows[3] = {OFF_PRE_LEN, 1'b0, 32'h0000_0000, 32'h0000_0000};
    rows[4] = {OFF_CNT_SET, 1'b0, 32'h0000_0000, 32'h0000_0002};
    rows[5] = {OFF_CNT_SET, 1'b1, 32'h0000_0001, 32'h0000_0002};
    rows[6] = {OFF_CNT_SET, 1'b1, 32'h0000_2711, 32'h0000_2710};
    rows[7] = {OFF_CNT_SET, 1'b1, 32'h0000_2710, 32'h0000_2710};
    rows[8] = {OFF_STATUS, 1'b1, 32'h0000_00FF, 32'h0000_0000};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(measuring, 1'b0); // idle after reset
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0000_0000, r, e);
      chk(r, rows[i].e); // reset values and count range
    end
    apb(1'b0, 8'h40, 32'h0000_0000, r, e);
    chk(e, 1'b1);
    wr(OFF_REC_LEN, 32'h0000_0014);
    wr(OFF_CNT_SET, 32'h0000_0002);
    wr(OFF_START_MASK, 32'h0000_0001);
    wr(OFF_STOP_MASK, 32'h0000_0001);
    // Function off: the start command records at once, one record, then halt.
    wr(OFF_CTRL, 32'h0000_0000);
    cond_req <= 8'h01;
    wr(OFF_CMD, 32'h0000_0001);
    wt(0, 1'b1, 4, n);
    chk(recording, 1'b1); // free run
    wt(0, 1'b0, 40, n);
    chk(n, 20); // record length
    wt(1, 1'b0, 4, n);
    chk(measuring, 1'b0); // single halt
    // Conditions already true at start must not fire in OR mode.
    cond_req <= 8'h03;
    wr(OFF_CTRL, 32'h0000_0001);
    repeat (8) @(posedge pclk);
    wr(OFF_CMD, 32'h0000_0001);
    wt(2, 1'b1, 4, n);
    chk(trig_wait, 1'b1); // standby
    cond_req <= 8'h01;
    repeat (8) @(posedge pclk);
    cond_req <= 8'h03;
    pulses(3, 20, n);
    chk(n, 0); // no edge
    cond_req <= 8'h02;
    repeat (8) @(posedge pclk);
    cond_req <= 8'h03;
    wt(3, 1'b1, 10, n);
    chk(trig_out, 1'b1); // trigger out
    chk(recording, 1'b1); // capture on trigger
    wt(1, 1'b0, 40, n);
    // AND fires at once, the disabled upper channels take no part.
    cond_req <= 8'h01;
    wr(OFF_CTRL, 32'h0000_0021);
    repeat (8) @(posedge pclk);
    wr(OFF_CMD, 32'h0000_0001);
    wt(3, 1'b1, 8, n);
    chk(trig_out, 1'b1); // immediate
    wt(1, 1'b0, 40, n);
    // Repeat: processing ignores triggers, then standby, then a double stop.
    cond_req <= 8'h00;
    wr(OFF_CTRL, 32'h0000_0003);
    repeat (8) @(posedge pclk);
    wr(OFF_CMD, 32'h0000_0001);
    wt(2, 1'b1, 4, n);
    cond_req <= 8'h01;
    wt(0, 1'b1, 10, n);
    wt(0, 1'b0, 30, n);
    cond_req <= 8'h00;
    repeat (6) @(posedge pclk);
    cond_req <= 8'h01;
    pulses(3, 10, n);
    chk(n, 0); // ignored in processing
    wt(2, 1'b1, 80, n);
    chk(trig_wait, 1'b1); // rearm
    cond_req <= 8'h00;
    repeat (8) @(posedge pclk);
    cond_req <= 8'h01;
    wt(0, 1'b1, 10, n);
    wr(OFF_CMD, 32'h0000_0002);
    chk(recording, 1'b1); // first stop finishes
    wr(OFF_CMD, 32'h0000_0002);
    wt(1, 1'b0, 3, n);
    chk(measuring, 1'b0); // second stop halts
    // Count mode in free run makes exactly two records.
    wr(OFF_CTRL, 32'h0000_0004);
    wr(OFF_CMD, 32'h0000_0001);
    pulses(0, 150, n);
    chk(n, 40); // two records
    chk(measuring, 1'b0); // halt
    // Stop timing in single mode ends on the stop trigger.
    cond_req <= 8'h00;
    wr(OFF_CTRL, 32'h0000_0009);
    repeat (8) @(posedge pclk);
    wr(OFF_CMD, 32'h0000_0001);
    wt(0, 1'b1, 4, n);
    cond_req <= 8'h01;
    wt(1, 1'b0, 12, n);
    chk(measuring, 1'b0); // stop ends
    // Start/stop timing: the first edge starts the record, the next one ends it.
    cond_req <= 8'h00;
    wr(OFF_CTRL, 32'h0000_0011);
    repeat (8) @(posedge pclk);
    wr(OFF_CMD, 32'h0000_0001);
    chk(trig_wait, 1'b1); // wait for start
    cond_req <= 8'h01;
    wt(0, 1'b1, 10, n);
    cond_req <= 8'h00;
    repeat (6) @(posedge pclk);
    cond_req <= 8'h01;
    wt(1, 1'b0, 12, n);
    chk(measuring, 1'b0); // stop trigger ends
    // Panel keys: an edge inside the pre-trigger portion is ignored, force starts.
    wr(OFF_PRE_LEN, 32'h0000_0010);
    cond_req <= 8'h00;
    wr(OFF_CTRL, 32'h0000_0001);
    repeat (8) @(posedge pclk);
    start_key <= 1'b1;
    wt(0, 1'b1, 8, n);
    cond_req <= 8'h01;
    pulses(3, 20, n);
    chk(n, 0); // ignored in pre-trigger
    chk(trig_wait, 1'b1); // standby follows
    force_key <= 1'b1;
    wt(3, 1'b1, 8, n);
    chk(recording, 1'b1); // force starts
    stop_key <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0000_0000, r, e);
    chk(r, 32'h0000_001B); // stop pending
    wt(1, 1'b0, 40, n);
    chk(measuring, 1'b0); // first stop finishes
    test_done();
  end
endmodule
